// ==== core/otm_output_mapper.sv ====
// file: top of the output terminal mapper with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module otm_output_mapper
  import otm_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic runMode,
  input wire logic [15:0] outputFreq,
  input wire logic [FUNC_COUNT-1:0] statusFuncs,
  output logic ocTerminalOut_n,
  output logic relayCoil
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    if (TICK_LEN < 1) $error("tick length must be at least one cycle");
  end

  logic [3:0] termFunc_r;
  logic [3:0] relayFunc_r;
  logic relayPol_r;
  otm_delay_type termDelay_r;
  otm_delay_type relayDelay_r;
  logic [15:0] startFreq_r;

  logic tick;
  logic runStatus;
  logic [FUNC_COUNT-1:0] funcVec;
  logic termSel;
  logic relaySel;
  logic termFilt;
  logic relayFilt;

  function automatic logic pick(input logic [FUNC_COUNT-1:0] v, input logic [3:0] code);
    pick = (code < 4'(FUNC_COUNT)) ? v[code] : 1'b0;
  endfunction : pick

  function automatic logic [9:0] clampDelay(input logic [31:0] d);
    clampDelay = (d > 32'(DELAY_MAX)) ? DELAY_MAX : d[9:0];
  endfunction : clampDelay

  ////////////////////////////////////////////////////////////////////////////
  // status function selection
  assign runStatus = runMode && (outputFreq > startFreq_r);

  always_comb begin
    funcVec = statusFuncs;
    funcVec[FUNC_RUN] = runStatus;
  end

  assign termSel = pick(funcVec, termFunc_r);
  assign relaySel = pick(funcVec, relayFunc_r);

  otm_tick_gen #(
    .CYCLES(TICK_LEN)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  otm_delay_filter u_term_filt (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .din(termSel),
    .delay(termDelay_r),
    .dout(termFilt)
  );

  otm_delay_filter u_relay_filt (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .din(relaySel),
    .delay(relayDelay_r),
    .dout(relayFilt)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ocTerminalOut_n <= 1'b1;
      relayCoil <= 1'b0;
    end else begin
      ocTerminalOut_n <= ~termFilt;
      relayCoil <= relayFilt ^ relayPol_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic wrHit;

  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_comb begin
    case (awAddr_r)
      ADDR_TERM_FUNC, ADDR_RELAY_FUNC, ADDR_RELAY_POL, ADDR_TERM_RISE,
      ADDR_TERM_FALL, ADDR_RELAY_RISE, ADDR_RELAY_FALL, ADDR_START_FREQ: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (s_axi_awready && s_axi_awvalid) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_r && !(s_axi_awready && s_axi_awvalid) && !s_axi_bvalid;
      s_axi_wready <= !wHeld_r && !(s_axi_wready && s_axi_wvalid) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      termFunc_r <= TERM_FUNC_RST;
      relayFunc_r <= RELAY_FUNC_RST;
      relayPol_r <= RELAY_POL_RST;
      termDelay_r <= '{rise: DELAY_RST, fall: DELAY_RST};
      relayDelay_r <= '{rise: DELAY_RST, fall: DELAY_RST};
      startFreq_r <= FREQ_RST;
    end else if (doWrite && wStrb_r[0]) begin
      case (awAddr_r)
        ADDR_TERM_FUNC: termFunc_r <= wData_r[3:0];
        ADDR_RELAY_FUNC: relayFunc_r <= wData_r[3:0];
        ADDR_RELAY_POL: relayPol_r <= wData_r[0];
        ADDR_TERM_RISE: termDelay_r.rise <= clampDelay(wData_r);
        ADDR_TERM_FALL: termDelay_r.fall <= clampDelay(wData_r);
        ADDR_RELAY_RISE: relayDelay_r.rise <= clampDelay(wData_r);
        ADDR_RELAY_FALL: relayDelay_r.fall <= clampDelay(wData_r);
        ADDR_START_FREQ: startFreq_r <= wStrb_r[1] ? wData_r[15:0] : {startFreq_r[15:8], wData_r[7:0]};
        default: termFunc_r <= termFunc_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  otm_rd_state_type rdState_r;
  logic [31:0] rdData;
  logic rdHit;

  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      ADDR_TERM_FUNC: rdData = {28'h0, termFunc_r};
      ADDR_RELAY_FUNC: rdData = {28'h0, relayFunc_r};
      ADDR_RELAY_POL: rdData = {31'h0, relayPol_r};
      ADDR_TERM_RISE: rdData = {22'h0, termDelay_r.rise};
      ADDR_TERM_FALL: rdData = {22'h0, termDelay_r.fall};
      ADDR_RELAY_RISE: rdData = {22'h0, relayDelay_r.rise};
      ADDR_RELAY_FALL: rdData = {22'h0, relayDelay_r.fall};
      ADDR_START_FREQ: rdData = {16'h0, startFreq_r};
      ADDR_STATUS: rdData = {27'h0, relayCoil, ~ocTerminalOut_n, relayFilt, termFilt, runStatus};
      default: begin
        rdData = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdState_r <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rdState_r)
        RD_IDLE: begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
            rdState_r <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rdState_r <= RD_IDLE;
          end
        end
        default: rdState_r <= RD_IDLE;
      endcase
    end
  end

endmodule : otm_output_mapper

// ==== common/otm_pkg.sv ====
// package: constants, register map and types for the output terminal mapper
package otm_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [9:0] DELAY_MAX = 10'h3E8;
  localparam logic [9:0] DELAY_RST = 10'h000;

  localparam logic [3:0] FUNC_RUN = 4'h0;
  localparam logic [3:0] FUNC_ALARM = 4'h5;
  localparam int FUNC_COUNT = 9;
  localparam logic [3:0] RELAY_FUNC_RST = FUNC_ALARM;
  localparam logic [3:0] TERM_FUNC_RST = FUNC_RUN;
  localparam logic RELAY_POL_RST = 1'b1;

  localparam logic [15:0] FREQ_RST = 16'h0000;

  localparam logic [7:0] ADDR_TERM_FUNC = 8'h00;
  localparam logic [7:0] ADDR_RELAY_FUNC = 8'h04;
  localparam logic [7:0] ADDR_RELAY_POL = 8'h08;
  localparam logic [7:0] ADDR_TERM_RISE = 8'h0C;
  localparam logic [7:0] ADDR_TERM_FALL = 8'h10;
  localparam logic [7:0] ADDR_RELAY_RISE = 8'h14;
  localparam logic [7:0] ADDR_RELAY_FALL = 8'h18;
  localparam logic [7:0] ADDR_START_FREQ = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [9:0] rise;
    logic [9:0] fall;
  } otm_delay_type;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } otm_rd_state_type;

endpackage : otm_pkg

// ==== core/otm_tick_gen.sv ====
// file: 0.1 s tick generator
`timescale 1ns/1ps
module otm_tick_gen
  import otm_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  initial begin
    if (CYCLES < 1) $error("tick period must be at least one cycle");
  end

  logic [31:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == 32'(CYCLES - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : otm_tick_gen

// ==== core/otm_delay_filter.sv ====
// file: on/off edge delay filter for one output
`timescale 1ns/1ps
module otm_delay_filter
  import otm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic din,
  input otm_delay_type delay,
  output logic dout
);
  logic [9:0] cnt_r;
  logic [9:0] limit;

  assign limit = din ? delay.rise : delay.fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 10'h000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= 10'h000;
    end else if (limit == 10'h000) begin
      cnt_r <= 10'h000;
      dout <= din;
    end else if (tick) begin
      if (cnt_r + 10'h001 >= limit) begin
        cnt_r <= 10'h000;
        dout <= din;
      end else begin
        cnt_r <= cnt_r + 10'h001;
      end
    end
  end
endmodule : otm_delay_filter

// ==== tb/otm_output_mapper_properties.sv ====
// checker: bus handshake and output idle assertions for the mapper top
`timescale 1ns/1ps
module otm_output_mapper_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ocTerminalOut_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  property p_rst_idle;
    $fell(rst) |-> ocTerminalOut_n;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("terminal sinks after reset");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read data repeated");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address open while busy");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write open while busy");
  property p_aw_held;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_held: assert property (p_aw_held) else $error("second write address taken");
endmodule : otm_output_mapper_properties

bind otm_output_mapper otm_output_mapper_properties u_props (
  .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .ocTerminalOut_n
);

// ==== tb/otm_relay_load.sv ====
// partner: relay contacts and indicator lamp hung on the mapper outputs
`timescale 1ns/1ps
module otm_relay_load (
  input wire logic ocTerminalOut_n,
  input wire logic relayCoil,
  output logic relayMakeContact,
  output logic relayBreakContact,
  output logic lampOn
);
  assign relayMakeContact = relayCoil;
  assign relayBreakContact = !relayCoil;
  assign lampOn = !ocTerminalOut_n;
endmodule : otm_relay_load

// ==== tb/otm_output_mapper_bench.sv ====
// bench: register, mapping and delay scenarios for the output terminal mapper
`timescale 1ns/1ps
module otm_output_mapper_bench
  import otm_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic runMode = 1'h0;
  logic [15:0] outputFreq = 16'h0000;
  logic [FUNC_COUNT-1:0] statusFuncs = 9'h000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic ocTerminalOut_n, relayCoil, relayMakeContact, relayBreakContact, lampOn;
  int n_fail = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  otm_output_mapper #(.TICK_LEN(10)) dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .runMode, .outputFreq, .statusFuncs,
    .ocTerminalOut_n, .relayCoil
  );
  otm_relay_load load (.ocTerminalOut_n, .relayCoil, .relayMakeContact,
    .relayBreakContact, .lampOn);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    logic pa;
    logic pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (pa && s_axi_awready) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end while (pa || pw);
    while (s_axi_bvalid !== 1'h1) @(posedge clk);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] er = 32'h0);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, er);
  endtask : rd

  task automatic drv(input logic rm, input logic [15:0] f, input logic [8:0] sf);
    @(posedge clk);
    runMode <= rm;
    outputFreq <= f;
    statusFuncs <= sf;
  endtask : drv

  // s selects the relay coil, else the terminal
  function automatic logic pick(input logic s);
    return s ? relayCoil : ocTerminalOut_n;
  endfunction : pick

  task automatic reach(input logic s, input int n, input logic e);
    for (int i = 0; i < n && pick(s) !== e; i++) @(posedge clk);
    chk({31'h0, pick(s)}, {31'h0, e});
  endtask : reach

  task automatic stay(input logic s, input int n, input logic e);
    repeat (n) begin
      @(posedge clk);
      chk({31'h0, pick(s)}, {31'h0, e});
    end
  endtask : stay
  ////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(ADDR_RELAY_FUNC, 32'h5);
    rd(ADDR_RELAY_POL, 32'h1);
    rd(ADDR_TERM_RISE, 32'h0);
    rd(ADDR_RELAY_FALL, 32'h0);
    chk({31'h0, relayBreakContact}, 32'h0);
    rd(8'h40, 32'h0, 32'h2);
    wr(8'h40, 32'h1, 32'h2);
    wr(ADDR_RELAY_RISE, 32'h7D0, 32'h0);
    rd(ADDR_RELAY_RISE, 32'h3E8);
    wr(ADDR_RELAY_RISE, 32'h0, 32'h0);
  endtask : t_defaults

  // bit 0 is ignored, so code 0 only goes active through run mode
  task automatic t_relay_map;
    wr(ADDR_RELAY_POL, 32'h0, 32'h0);
    for (int c = 0; c < FUNC_COUNT; c++) begin
      wr(ADDR_RELAY_FUNC, 32'(c), 32'h0);
      drv(1'(c == 0), 16'h0005, 9'(9'h1 << c));
      reach(1'h1, 4, 1'h1);
      drv(1'h0, 16'h0005, 9'h000);
      reach(1'h1, 4, 1'h0);
    end
    wr(ADDR_RELAY_POL, 32'h1, 32'h0);
    reach(1'h1, 4, 1'h1);
    chk({31'h0, relayMakeContact}, 32'h1);
  endtask : t_relay_map

  task automatic t_run_start;
    wr(ADDR_START_FREQ, 32'h64, 32'h0);
    drv(1'h1, 16'h0064, 9'h000);
    stay(1'h0, 6, 1'h1);
    drv(1'h1, 16'h0065, 9'h000);
    reach(1'h0, 4, 1'h0);
    chk({31'h0, lampOn}, 32'h1);
    rd(ADDR_STATUS, 32'h1B);
    drv(1'h0, 16'h0065, 9'h000);
    reach(1'h0, 4, 1'h1);
  endtask : t_run_start

  // alarm on the terminal while the relay carries code 8
  task automatic t_delays;
    wr(ADDR_TERM_FUNC, 32'h5, 32'h0);
    wr(ADDR_TERM_RISE, 32'h3, 32'h0);
    drv(1'h0, 16'h0000, 9'h120);
    reach(1'h1, 4, 1'h0);
    stay(1'h0, 11, 1'h1);
    drv(1'h0, 16'h0000, 9'h000);
    stay(1'h0, 40, 1'h1);
    drv(1'h0, 16'h0000, 9'h020);
    stay(1'h0, 18, 1'h1);
    reach(1'h0, 16, 1'h0);
    wr(ADDR_TERM_FALL, 32'h2, 32'h0);
    drv(1'h0, 16'h0000, 9'h000);
    stay(1'h0, 8, 1'h0);
    drv(1'h0, 16'h0000, 9'h020);
    stay(1'h0, 30, 1'h0);
    drv(1'h0, 16'h0000, 9'h000);
    stay(1'h0, 9, 1'h0);
    reach(1'h0, 16, 1'h1);
  endtask : t_delays

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_defaults();
    t_relay_map();
    t_run_start();
    t_delays();
    finish_test();
  end

  // tests need about 400 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : otm_output_mapper_bench
